//--- common/pvic_regs.vh
// Register offsets, field positions, reset values and vectors of the pvic
`ifndef PVIC_REGS_VH
`define PVIC_REGS_VH

// Byte offsets on the Wishbone bus, one aligned word each
`define PVIC_OFF_REQ0 8'h00
`define PVIC_OFF_EN0H 8'h04
`define PVIC_OFF_EN0L 8'h08
`define PVIC_OFF_REQ1 8'h0C
`define PVIC_OFF_EN1H 8'h10
`define PVIC_OFF_EN1L 8'h14
`define PVIC_OFF_REQ2 8'h18
`define PVIC_OFF_EN2H 8'h1C
`define PVIC_OFF_EN2L 8'h20
`define PVIC_OFF_CTRL 8'h24
`define PVIC_OFF_STAT 8'h28
`define PVIC_OFF_PAEDGE 8'h2C

// Implemented bits of the groups; reserved bits read zero
`define PVIC_MASK_GRP0 8'h61
`define PVIC_MASK_GRP1 8'hFF
`define PVIC_MASK_GRP2 8'h0F

// Field positions
`define PVIC_BIT_T1 6
`define PVIC_BIT_T0 5
`define PVIC_BIT_ADC 0
`define PVIC_BIT_GIE 7
`define PVIC_BIT_WDTEN 0
`define PVIC_BIT_STAT_VALID 7

// Reset values
`define PVIC_RST_REG 8'h00
`define PVIC_RST_PAEDGE 8'hFF

// Source index in fixed order, highest first
`define PVIC_SRC_WDT 5'h00
`define PVIC_SRC_POSC 5'h01
`define PVIC_SRC_WOSC 5'h02
`define PVIC_SRC_ILL 5'h03
`define PVIC_SRC_T1 5'h04
`define PVIC_SRC_T0 5'h05
`define PVIC_SRC_ADC 5'h06
`define PVIC_SRC_PA7 5'h07
`define PVIC_SRC_PC3 5'h0F
`define PVIC_NUM_SRC 19

// Program-memory vector addresses
`define PVIC_VEC_RESET 16'h0002
`define PVIC_VEC_WDT 16'h0004
`define PVIC_VEC_ILL 16'h0006
`define PVIC_VEC_T1 16'h000A
`define PVIC_VEC_T0 16'h000C
`define PVIC_VEC_ADC 16'h0016
`define PVIC_VEC_PA7 16'h0018
`define PVIC_VEC_PA6 16'h001A
`define PVIC_VEC_PA0 16'h0026
`define PVIC_VEC_PC3 16'h0030
`define PVIC_VEC_PC0 16'h0036
`define PVIC_VEC_POSC 16'h003A
`define PVIC_VEC_WOSC 16'h003C
`define PVIC_VEC_STEP 16'h0002

`define PVIC_LVL_OFF 2'b00
`define PVIC_LVL_TOP 2'b11

`endif

//--- hdl/pvic_top.v
// Prioritizing vectored interrupt controller with Wishbone register slave
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "pvic_regs.vh"

// Operation
// - Nineteen sources; comparator shares port_a_pin6 slot
// - Port A pins 7..0, selectable edge, successive vectors
// - Port C pins 3..0, both edges, successive vectors
// - Vector word: MSB even address, LSB odd
// - Fixed order: timers, ADC, port A, port C
// - Reset and watchdog head the order
// - Three traps own vectors, after watchdog
// - Enable flag set by instructions or write
// - Enable flag cleared by acks, traps, writes
// - Level 3 beats 2 beats 1
// - Same level: fixed order decides
// - Traps are always level 3; watchdog level 3 when wdt_en, else off
// - One-cycle request pulses latch into pending
// - Acknowledge clears the served pending bit
// - Writing zero clears a pending bit
// - Writing one raises a software request
// - Enable flag clear: only traps interrupt, bits readable
// - Winner presented to CPU with its vector
// - Enable bit pair encodes level or off
// - Pending reads one; forwarded only when enabled
module pvic_top #(
   parameter PA_PINS = 8,
   parameter PC_PINS = 4
) (
   // System
   input wire clk_i,
   input wire resetn_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Peripheral request pulses
   input wire timer1_irq_i,
   input wire timer0_irq_i,
   input wire adc_irq_i,
   input wire comp_irq_i,
   input wire wdt_irq_i,
   // Trap pulses
   input wire posc_fail_i,
   input wire wosc_fail_i,
   input wire illegal_instr_i,
   // Port pins, asynchronous
   input wire [PA_PINS-1:0] port_a_pin_i,
   input wire [PC_PINS-1:0] port_c_pin_i,
   // CPU core
   input wire enable_interrupts_instruction_i,
   input wire disable_interrupts_instruction_i,
   input wire return_from_interrupt_instruction_i,
   input wire trap_instruction_i,
   input wire cpu_ack_i,
   output wire irq_req_o,
   output reg [4:0] irq_src_o,
   output reg [15:0] vector_addr_o,
   output reg [15:0] vector_lsb_addr_o,
   output wire global_irq_enable_flag_o
);

   // Source count includes the watchdog and the three fixed level-3 traps
   localparam NS = `PVIC_NUM_SRC;

   // Vector lookup; shared by the presented winner only, but kept
   // as a function so the slot arithmetic lives in one place
   function [15:0] vec_of;
      input [4:0] idx;
      begin
         case (idx)
            `PVIC_SRC_WDT: vec_of = `PVIC_VEC_WDT;
            `PVIC_SRC_POSC: vec_of = `PVIC_VEC_POSC;
            `PVIC_SRC_WOSC: vec_of = `PVIC_VEC_WOSC;
            `PVIC_SRC_ILL: vec_of = `PVIC_VEC_ILL;
            `PVIC_SRC_T1: vec_of = `PVIC_VEC_T1;
            `PVIC_SRC_T0: vec_of = `PVIC_VEC_T0;
            `PVIC_SRC_ADC: vec_of = `PVIC_VEC_ADC;
            default:
            begin
               // Port pins sit on consecutive two-byte slots
               if (idx < `PVIC_SRC_PC3)
                  vec_of = `PVIC_VEC_PA7 + `PVIC_VEC_STEP *
                     {11'h000, idx - `PVIC_SRC_PA7};
               else
                  vec_of = `PVIC_VEC_PC3 + `PVIC_VEC_STEP *
                     {11'h000, idx - `PVIC_SRC_PC3};
            end
         endcase
      end
   endfunction

   // Pending and its next value, one bit per source index
   reg [NS-1:0] pend;
   reg [NS-1:0] next_pend;
   // Enable bit pairs per group, high and low halves
   reg [7:0] en0h;
   reg [7:0] en0l;
   reg [7:0] en1h;
   reg [7:0] en1l;
   reg [7:0] en2h;
   reg [7:0] en2l;
   reg [7:0] pa_edge;
   // Global enable flag and watchdog request enable
   reg gie;
   reg next_gie;
   reg wdt_en;
   // Pin synchronisers and edge-detector history
   reg [PA_PINS-1:0] pa_s1;
   reg [PA_PINS-1:0] pa_s2;
   reg [PA_PINS-1:0] pa_s3;
   reg [PC_PINS-1:0] pc_s1;
   reg [PC_PINS-1:0] pc_s2;
   reg [PC_PINS-1:0] pc_s3;
   // Arbitration state and helpers
   reg win_valid;
   reg [NS-1:0] hw_set;
   reg [2*NS-1:0] lvl_flat;
   reg [NS-1:0] cand;
   reg [1:0] best_lvl;
   reg [4:0] best_idx;
   reg best_ok;
   reg [7:0] rd_data;
   // Bus decode and edge events
   wire [PA_PINS-1:0] pa_evt;
   wire [PC_PINS-1:0] pc_evt;
   wire bus_req;
   wire bus_wr;
   wire wr_b0;
   wire ack_take;
   integer i;

   // Bus access decode; one-cycle wait then ack
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;
   assign wr_b0 = bus_wr & wb_sel_i[0];

   assign ack_take = cpu_ack_i & win_valid;
   assign irq_req_o = win_valid;
   assign global_irq_enable_flag_o = gie;

   // Pins cross two flops; third stage only feeds the edge detector
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pa_s1 <= {PA_PINS{1'b0}};
         pa_s2 <= {PA_PINS{1'b0}};
         pa_s3 <= {PA_PINS{1'b0}};
         pc_s1 <= {PC_PINS{1'b0}};
         pc_s2 <= {PC_PINS{1'b0}};
         pc_s3 <= {PC_PINS{1'b0}};
      end
      else
      begin
         pa_s1 <= port_a_pin_i;
         pa_s2 <= pa_s1;
         pa_s3 <= pa_s2;
         pc_s1 <= port_c_pin_i;
         pc_s2 <= pc_s1;
         pc_s3 <= pc_s2;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PA_PINS; g = g + 1)
      begin : g_pa
         // Edge select: one for rising, zero for falling
         assign pa_evt[g] = pa_edge[g] ? (pa_s2[g] & ~pa_s3[g])
                                       : (~pa_s2[g] & pa_s3[g]);
      end
      for (g = 0; g < PC_PINS; g = g + 1)
      begin : g_pc
         assign pc_evt[g] = pc_s2[g] ^ pc_s3[g];
      end
   endgenerate

   // Hardware request pulses into source order
   always @*
   begin
      hw_set = {NS{1'b0}};
      hw_set[`PVIC_SRC_WDT] = wdt_irq_i;
      hw_set[`PVIC_SRC_POSC] = posc_fail_i;
      hw_set[`PVIC_SRC_WOSC] = wosc_fail_i;
      hw_set[`PVIC_SRC_ILL] = illegal_instr_i;
      hw_set[`PVIC_SRC_T1] = timer1_irq_i;
      hw_set[`PVIC_SRC_T0] = timer0_irq_i;
      hw_set[`PVIC_SRC_ADC] = adc_irq_i;
      for (i = 0; i < PA_PINS; i = i + 1)
         hw_set[14-i] = pa_evt[i];
      // Comparator merges into the pin 6 slot
      hw_set[8] = pa_evt[6] | comp_irq_i;
      for (i = 0; i < PC_PINS; i = i + 1)
         hw_set[18-i] = pc_evt[i];
   end

   // Pending bits: ack and software write, then hardware set on top
   always @*
   begin
      next_pend = pend;
      if (ack_take)
         next_pend[irq_src_o] = 1'b0;
      if (wr_b0 && wb_adr_i == `PVIC_OFF_REQ0)
      begin
         next_pend[`PVIC_SRC_T1] = wb_dat_i[`PVIC_BIT_T1];
         next_pend[`PVIC_SRC_T0] = wb_dat_i[`PVIC_BIT_T0];
         next_pend[`PVIC_SRC_ADC] = wb_dat_i[`PVIC_BIT_ADC];
      end
      if (wr_b0 && wb_adr_i == `PVIC_OFF_REQ1)
         for (i = 0; i < 8; i = i + 1)
            next_pend[14-i] = wb_dat_i[i];
      if (wr_b0 && wb_adr_i == `PVIC_OFF_REQ2)
         for (i = 0; i < 4; i = i + 1)
            next_pend[18-i] = wb_dat_i[i];
      // A fresh pulse beats any clear in the same cycle
      next_pend = next_pend | hw_set;
   end

   // Global enable: clears take precedence over sets
   always @*
   begin
      next_gie = gie;
      if (enable_interrupts_instruction_i ||
          return_from_interrupt_instruction_i)
         next_gie = 1'b1;
      if (wr_b0 && wb_adr_i == `PVIC_OFF_CTRL)
         next_gie = wb_dat_i[`PVIC_BIT_GIE];
      if (disable_interrupts_instruction_i || ack_take ||
          trap_instruction_i || illegal_instr_i ||
          posc_fail_i || wosc_fail_i)
         next_gie = 1'b0;
   end

   // Levels: traps fixed at top, watchdog from wdt_en, rest from the enable bit pairs
   always @*
   begin
      lvl_flat = {2*NS{1'b0}};
      lvl_flat[1:0] = wdt_en ? `PVIC_LVL_TOP : `PVIC_LVL_OFF;
      lvl_flat[3:2] = `PVIC_LVL_TOP;
      lvl_flat[5:4] = `PVIC_LVL_TOP;
      lvl_flat[7:6] = `PVIC_LVL_TOP;
      lvl_flat[9:8] = {en0h[`PVIC_BIT_T1], en0l[`PVIC_BIT_T1]};
      lvl_flat[11:10] = {en0h[`PVIC_BIT_T0], en0l[`PVIC_BIT_T0]};
      lvl_flat[13:12] = {en0h[`PVIC_BIT_ADC], en0l[`PVIC_BIT_ADC]};
      for (i = 0; i < 8; i = i + 1)
         lvl_flat[2*(14-i) +: 2] = {en1h[i], en1l[i]};
      for (i = 0; i < 4; i = i + 1)
         lvl_flat[2*(18-i) +: 2] = {en2h[i], en2l[i]};
   end

   // Candidates: traps always, others only with the enable flag
   always @*
   begin
      for (i = 0; i < NS; i = i + 1)
         cand[i] = pend[i] && (lvl_flat[2*i +: 2] != `PVIC_LVL_OFF) &&
                   (gie || (i >= 1 && i <= 3));
   end

   // Scan from lowest rank up so ties settle on the higher rank
   always @*
   begin
      best_lvl = `PVIC_LVL_OFF;
      best_idx = 5'h00;
      best_ok = 1'b0;
      for (i = NS - 1; i >= 0; i = i - 1)
      begin
         if (cand[i] && lvl_flat[2*i +: 2] >= best_lvl)
         begin
            best_lvl = lvl_flat[2*i +: 2];
            best_idx = i[4:0];
            best_ok = 1'b1;
         end
      end
   end

   // Register read mux; trap and watchdog pending bits are not
   // visible here, software sees only the programmable sources
   always @*
   begin
      case (wb_adr_i)
         `PVIC_OFF_REQ0:
            rd_data = {1'b0, pend[`PVIC_SRC_T1], pend[`PVIC_SRC_T0],
                       4'h0, pend[`PVIC_SRC_ADC]};
         `PVIC_OFF_EN0H: rd_data = en0h;
         `PVIC_OFF_EN0L: rd_data = en0l;
         `PVIC_OFF_REQ1:
            rd_data = {pend[7], pend[8], pend[9], pend[10],
                       pend[11], pend[12], pend[13], pend[14]};
         `PVIC_OFF_EN1H: rd_data = en1h;
         `PVIC_OFF_EN1L: rd_data = en1l;
         `PVIC_OFF_REQ2:
            rd_data = {4'h0, pend[15], pend[16], pend[17], pend[18]};
         `PVIC_OFF_EN2H: rd_data = en2h;
         `PVIC_OFF_EN2L: rd_data = en2l;
         `PVIC_OFF_CTRL: rd_data = {gie, 6'h00, wdt_en};
         `PVIC_OFF_STAT: rd_data = {win_valid, 2'b00, irq_src_o};
         `PVIC_OFF_PAEDGE: rd_data = pa_edge;
         default: rd_data = 8'h00;
      endcase
   end

   // Registers and bus answer; a write lands at the taking edge,
   // one edge before the master sees ack
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pend <= {NS{1'b0}};
         gie <= 1'b0;
         wdt_en <= 1'b0;
         en0h <= `PVIC_RST_REG;
         en0l <= `PVIC_RST_REG;
         en1h <= `PVIC_RST_REG;
         en1l <= `PVIC_RST_REG;
         en2h <= `PVIC_RST_REG;
         en2l <= `PVIC_RST_REG;
         pa_edge <= `PVIC_RST_PAEDGE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         pend <= next_pend;
         gie <= next_gie;
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i)
            wb_dat_o <= {24'h00_0000, rd_data};
         if (wr_b0)
         begin
            case (wb_adr_i)
               `PVIC_OFF_EN0H: en0h <= wb_dat_i[7:0] & `PVIC_MASK_GRP0;
               `PVIC_OFF_EN0L: en0l <= wb_dat_i[7:0] & `PVIC_MASK_GRP0;
               `PVIC_OFF_EN1H: en1h <= wb_dat_i[7:0] & `PVIC_MASK_GRP1;
               `PVIC_OFF_EN1L: en1l <= wb_dat_i[7:0] & `PVIC_MASK_GRP1;
               `PVIC_OFF_EN2H: en2h <= wb_dat_i[7:0] & `PVIC_MASK_GRP2;
               `PVIC_OFF_EN2L: en2l <= wb_dat_i[7:0] & `PVIC_MASK_GRP2;
               `PVIC_OFF_CTRL: wdt_en <= wb_dat_i[`PVIC_BIT_WDTEN];
               `PVIC_OFF_PAEDGE: pa_edge <= wb_dat_i[7:0];
               default: ;
            endcase
         end
      end
   end

   // Presented winner; dropped for one cycle after an ack so the
   // stale source is never offered twice
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         win_valid <= 1'b0;
         irq_src_o <= 5'h00;
         vector_addr_o <= `PVIC_VEC_RESET;
         vector_lsb_addr_o <= `PVIC_VEC_RESET + 16'h0001;
      end
      else if (ack_take)
      begin
         win_valid <= 1'b0;
      end
      else
      begin
         win_valid <= best_ok;
         irq_src_o <= best_idx;
         vector_addr_o <= vec_of(best_idx);
         vector_lsb_addr_o <= vec_of(best_idx) | 16'h0001;
      end
   end

endmodule // pvic_top

`default_nettype wire

//--- bench/pvic_monitor.sv
// Concurrent checks on the pvic bus, enable flag and vector outputs
`timescale 1ns/1ns
`default_nettype none
module pvic_monitor (
   // System
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   // Flag events
   input wire logic posc_fail_i,
   input wire logic wosc_fail_i,
   input wire logic illegal_instr_i,
   input wire logic enable_interrupts_instruction_i,
   input wire logic disable_interrupts_instruction_i,
   input wire logic return_from_interrupt_instruction_i,
   input wire logic trap_instruction_i,
   // CPU side
   input wire logic cpu_ack_i,
   input wire logic irq_req_o,
   input wire logic [4:0] irq_src_o,
   input wire logic [15:0] vector_addr_o,
   input wire logic [15:0] vector_lsb_addr_o,
   input wire logic global_irq_enable_flag_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic clr_ev;
   logic set_ev;
   assign clr_ev = disable_interrupts_instruction_i || trap_instruction_i
      || posc_fail_i || wosc_fail_i || illegal_instr_i;
   // Any bus write may hit the control byte, so it masks a set
   assign set_ev = (enable_interrupts_instruction_i
      || return_from_interrupt_instruction_i) && !clr_ev
      && !(cpu_ack_i && irq_req_o) && !(wb_cyc_i && wb_stb_i && wb_we_i);
   function automatic logic [15:0] vec_of(input logic [4:0] s);
      case (s)
         5'h00: return 16'h0004;
         5'h01: return 16'h003A;
         5'h02: return 16'h003C;
         5'h03: return 16'h0006;
         5'h04: return 16'h000A;
         5'h05: return 16'h000C;
         5'h06: return 16'h0016;
         default: return (s < 5'h0F) ? 16'h0018 + 16'({s - 5'h07, 1'b0})
            : 16'h0030 + 16'({s - 5'h0F, 1'b0});
      endcase
   endfunction
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_served;
      cpu_ack_i && irq_req_o;
   endsequence
   AST_ACK_NEXT: assert property (s_taken |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   property p_lsb_odd;
      vector_lsb_addr_o == vector_addr_o + 16'h0001;
   endproperty
   property p_vec_map;
      irq_req_o |-> vector_addr_o == vec_of(irq_src_o);
   endproperty
   property p_ack_clears;
      s_served |=> !irq_req_o && !global_irq_enable_flag_o;
   endproperty
   property p_polled;
      irq_req_o && !global_irq_enable_flag_o
         && !$past(global_irq_enable_flag_o)
         |-> irq_src_o inside {[5'h01:5'h03]};
   endproperty
   AST_LSB_ODD: assert property (p_lsb_odd)
      else $error("low vector byte not at next address");
   AST_VEC_MAP: assert property (p_vec_map)
      else $error("vector does not match source");
   AST_ACK_CLEARS: assert property (p_ack_clears)
      else $error("acknowledge did not drop request and flag");
   AST_CLR_FLAG: assert property (clr_ev |=> !global_irq_enable_flag_o)
      else $error("enable flag not cleared");
   AST_SET_FLAG: assert property (set_ev |=> global_irq_enable_flag_o)
      else $error("enable flag not set");
   AST_POLLED: assert property (p_polled)
      else $error("request forwarded with flag clear");
endmodule // pvic_monitor
bind pvic_top pvic_monitor mon (.clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_ack_o, .posc_fail_i, .wosc_fail_i, .illegal_instr_i,
   .enable_interrupts_instruction_i, .disable_interrupts_instruction_i,
   .return_from_interrupt_instruction_i, .trap_instruction_i, .cpu_ack_i,
   .irq_req_o, .irq_src_o, .vector_addr_o, .vector_lsb_addr_o,
   .global_irq_enable_flag_o);
`default_nettype wire

//--- bench/pvic_cpu_model.sv
// CPU core model: waits, acknowledges, then returns from the routine
`timescale 1ns/1ns
`default_nettype none
module pvic_cpu_model (
   // System
   input wire logic clk_i,
   input wire logic resetn_i,
   // Controller side
   input wire logic irq_i,
   input wire logic [4:0] src_i,
   input wire logic [3:0] lat_i,
   output logic ack_o,
   output logic ret_o,
   output logic [4:0] seen_src_o
);
   logic [3:0] wait_cnt;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         seen_src_o <= 5'h00;
         wait_cnt <= 4'h0;
      end
      else
      begin
         ack_o <= 1'b0;
         // Return one cycle after each acknowledge re-enables the flag
         ret_o <= ack_o;
         wait_cnt <= 4'h0;
         // Acknowledge only a standing request, after a chosen delay
         if (irq_i && !ack_o && wait_cnt != lat_i)
            wait_cnt <= wait_cnt + 4'h1;
         else if (irq_i && !ack_o)
         begin
            ack_o <= 1'b1;
            seen_src_o <= src_i;
         end
      end
   end
endmodule // pvic_cpu_model
`default_nettype wire

//--- bench/priority_vectored_interrupt_ctrl_tb.sv
// Self-checking bench of the pvic with a bench-side arbitration model
`timescale 1ns/1ns
`default_nettype none
`include "pvic_regs.vh"
module priority_vectored_interrupt_ctrl_tb;
   logic clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i, port_a_pin_i, pa_n, q, pe;
   logic [3:0] wb_sel_i, port_c_pin_i, pc_n, lat;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [10:0] ev, m;
   logic cpu_ack_i, ret, irq_req_o, global_irq_enable_flag_o;
   logic [4:0] irq_src_o, seen;
   logic [15:0] vector_addr_o, vector_lsb_addr_o;
   logic [7:0] pnd[3], eh[3], el[3];
   logic [7:0] mk[3] = '{`PVIC_MASK_GRP0, `PVIC_MASK_GRP1, `PVIC_MASK_GRP2};
   logic [10:0] clr_ev[5] = '{11'h002, 11'h001, 11'h020, 11'h010, 11'h008};
   int clr_src[5] = '{-1, -1, 1, 2, 3};
   int n_checks, n_mismatch, cycles, i, g, w;
   pvic_top DUT (.clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer1_irq_i(ev[10]),
      .timer0_irq_i(ev[9]), .adc_irq_i(ev[8]), .comp_irq_i(ev[7]),
      .wdt_irq_i(ev[6]), .posc_fail_i(ev[5]), .wosc_fail_i(ev[4]),
      .illegal_instr_i(ev[3]), .enable_interrupts_instruction_i(ev[2]),
      .disable_interrupts_instruction_i(ev[1]), .trap_instruction_i(ev[0]),
      .return_from_interrupt_instruction_i(ret), .port_a_pin_i, .port_c_pin_i,
      .cpu_ack_i, .irq_req_o, .irq_src_o, .vector_addr_o, .vector_lsb_addr_o,
      .global_irq_enable_flag_o);
   pvic_cpu_model cpu (.clk_i, .resetn_i, .irq_i(irq_req_o), .src_i(irq_src_o),
      .lat_i(lat), .ack_o(cpu_ack_i), .ret_o(ret), .seen_src_o(seen));
   function automatic int grp(int s);
      return s < 7 ? 0 : (s < 15 ? 1 : 2);
   endfunction
   function automatic int bitn(int s);
      return s == 4 ? 6 : s == 5 ? 5 : s == 6 ? 0 : s < 15 ? 14 - s : 18 - s;
   endfunction
   // Highest level first, then fixed order within a level
   function automatic int winner();
      for (int lv = 3; lv > 0; lv--)
         for (int s = 4; s < 19; s++)
            if (pnd[grp(s)][bitn(s)] && {eh[grp(s)][bitn(s)], el[grp(s)][bitn(s)]} == lv)
               return s;
      return -1;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [10:0] pm);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      ev <= pm;
      n = 0;
      do
      begin
         @(posedge clk_i);
         ev <= 11'h000;
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      // A missing ack counts as a mismatch
      if (n >= 20)
         n_mismatch++;
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00, 11'h000);
      check(q, exp);
   endtask
   task automatic pulse(input logic [10:0] pm);
      @(posedge clk_i);
      ev <= pm;
      @(posedge clk_i);
      ev <= 11'h000;
      @(posedge clk_i);
   endtask
   task automatic serve(input int exp);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (cpu_ack_i !== 1'b1 && n < 40);
      check(cpu_ack_i, 1'b1);
      check(seen, exp);
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial
   begin
      {resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, ev, port_a_pin_i, port_c_pin_i} = '0;
      {wb_adr_i, wb_dat_i, lat, cycles} = '0;
      wb_sel_i = 4'h1;
      for (g = 0; g < 3; g++)
         {pnd[g], eh[g], el[g]} = '0;
      void'($urandom(32'h1de2_d5bc));
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      check(vector_addr_o, `PVIC_VEC_RESET);
      check(global_irq_enable_flag_o, 1'b0);
      rd(`PVIC_OFF_PAEDGE, `PVIC_RST_PAEDGE);
      rd(`PVIC_OFF_CTRL, `PVIC_RST_REG);
      rd(8'h3C, 8'h00);
      for (i = 0; i < 5; i++)
      begin
         pulse(11'h004);
         check(global_irq_enable_flag_o, 1'b1);
         pulse(clr_ev[i]);
         check(global_irq_enable_flag_o, 1'b0);
         if (clr_src[i] >= 0)
            serve(clr_src[i]);
      end
      wb(1'b1, `PVIC_OFF_EN0H, 8'h40, 11'h000);
      wb(1'b1, `PVIC_OFF_EN0L, 8'h40, 11'h000);
      wb(1'b1, `PVIC_OFF_CTRL, 8'h81, 11'h000);
      pulse(11'h440);
      serve(0);
      serve(4);
      wb(1'b1, `PVIC_OFF_CTRL, 8'h00, 11'h000);
      pulse(11'h400);
      repeat (2) @(posedge clk_i);
      check(irq_req_o, 1'b0);
      rd(`PVIC_OFF_REQ0, 8'h40);
      wb(1'b1, `PVIC_OFF_REQ0, 8'h00, 11'h200);
      rd(`PVIC_OFF_REQ0, 8'h20);
      wb(1'b1, `PVIC_OFF_REQ0, 8'h00, 11'h000);
      for (i = 0; i < 30; i++)
      begin
         lat <= 4'($urandom % 4);
         for (g = 0; g < 3; g++)
         begin
            eh[g] = 8'($urandom) & mk[g];
            el[g] = 8'($urandom) & mk[g];
            pnd[g] = 8'($urandom) & mk[g];
            wb(1'b1, 8'(12 * g + 4), eh[g], 11'h000);
            wb(1'b1, 8'(12 * g + 8), el[g], 11'h000);
            wb(1'b1, 8'(12 * g), pnd[g], 11'h000);
         end
         pa_n = 8'($urandom);
         pc_n = 4'($urandom);
         pe = 8'($urandom);
         wb(1'b1, `PVIC_OFF_PAEDGE, pe, 11'h000);
         pnd[1] = pnd[1] | (pe & pa_n & ~port_a_pin_i)
            | (~pe & ~pa_n & port_a_pin_i);
         pnd[2] = pnd[2] | {4'h0, pc_n ^ port_c_pin_i};
         port_a_pin_i <= pa_n;
         port_c_pin_i <= pc_n;
         repeat (5) @(posedge clk_i);
         m = 11'($urandom) & 11'h780;
         pnd[0] = pnd[0] | {1'b0, m[10], m[9], 4'h0, m[8]};
         pnd[1][6] = pnd[1][6] | m[7];
         pulse(m);
         for (g = 0; g < 3; g++)
            rd(8'(12 * g), pnd[g]);
         wb(1'b1, `PVIC_OFF_CTRL, 8'h80, 11'h000);
         while ((w = winner()) >= 0)
         begin
            serve(w);
            pnd[grp(w)][bitn(w)] = 1'b0;
         end
         wb(1'b1, `PVIC_OFF_CTRL, 8'h00, 11'h000);
         check(global_irq_enable_flag_o, 1'b0);
      end
      report_and_stop();
   end
endmodule // priority_vectored_interrupt_ctrl_tb
`default_nettype wire
